// ### logic/adiu_pkg.sv
package adiu_pkg;
    // One bit per event source, ordered as the register bits 5..1
    typedef struct packed {
        logic bus_fall;
        logic overtemperature;
        logic undervoltage;
        logic overvoltage;
        logic overcurrent;
    } adiu_evt_type;
    // Register write request from the serial port
    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [7:0] data;
    } adiu_wreq_type;
endpackage

// ### logic/adiu_regs.svh
// What this block does
// R1: Five event sources, each with own flag
// R2: Controller enables each source over serial port
// R3: All sources disabled after any reset
// R4: Undervoltage sets flag, interrupts only if enabled
// R5: Undervoltage forces high-side switches off only
// R6: Overvoltage sets flag, interrupts only if enabled
// R7: Overvoltage forces high-side switches off only
// R8: Overtemperature sets flag, interrupts if enabled
// R9: Bus falling edge interrupts when enabled
// R10: Overcurrent on bridge or 5V output interrupts
// R11: Flag register layout, unused bits zero
// R12: Bus flag set per edge, write-one clears
// R13: Overtemperature clear ignored while condition persists
// R14: Undervoltage clear only after condition ended
// R15: Open-drain interrupt output to controller
// R16: Overvoltage clear ignored while condition persists
// R17: Enable register layout, bits five to one
// R18: Overcurrent flag cleared from system status
// R19: Interrupt low while any enabled flag set
`ifndef ADIU_REGS_SVH
`define ADIU_REGS_SVH
// Register addresses on the serial port
`define ADIU_ADDR_ENABLE 5'h04
`define ADIU_ADDR_FLAGS 5'h05
// Field positions within both registers
`define ADIU_BIT_BUS 5
`define ADIU_BIT_OT 4
`define ADIU_BIT_UV 3
`define ADIU_BIT_OV 2
`define ADIU_BIT_OC 1
// Reset value of both registers
`define ADIU_RESET_VALUE 8'h00
// Serial frame length and read-data load point, in sample edges
`define ADIU_FRAME_EDGES 5'h10
`define ADIU_LOAD_EDGE 5'h08
`endif

// ### logic/adiu_spi_slave.sv
`timescale 1ns/100ps
`include "adiu_regs.svh"
module adiu_spi_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic ss_n_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] rd_data,
    output logic [4:0] rd_addr,
    output logic miso,
    output logic miso_oe,
    output adiu_pkg::adiu_wreq_type wreq
);
    import adiu_pkg::*;

    // First and second synchroniser stages, plus delayed copy for edges
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic ss_n_d;
    logic sck_d;
    // Edge count, received bits, outgoing bits
    logic [4:0] cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic [4:0] next_cnt;
    logic [15:0] next_shift_in;
    logic [7:0] next_shift_out;
    logic next_miso;
    adiu_wreq_type next_wreq;
    // Decoded synchronised pins
    logic ss_n_s;
    logic sck_s;
    logic mosi_s;
    logic sck_rise;
    logic sck_fall;
    logic ss_fall;
    logic ss_rise;
    logic parity_ok;

    assign ss_n_s = sync2[2];
    assign sck_s = sync2[1];
    assign mosi_s = sync2[0];
    assign sck_rise = sck_s & ~sck_d & ~ss_n_s;
    assign sck_fall = ~sck_s & sck_d & ~ss_n_s;
    assign ss_fall = ~ss_n_s & ss_n_d;
    assign ss_rise = ss_n_s & ~ss_n_d;
    // At the load edge seven bits are in: rw, five address bits, parity
    assign rd_addr = shift_in[5:1];
    assign parity_ok = (^shift_in[15:10]) == shift_in[9];

    ////////////////////////////////////////////////////////////////////
    // Frame sequencing
    always_comb begin
        next_cnt = cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_miso = miso;
        next_wreq = '0;
        // New frame: restart count, preload the status byte
        if (ss_fall) begin
            next_cnt = 5'h00;
            next_shift_out = status_byte;
        end
        // Output changes on the rising serial clock
        if (sck_rise) begin
            next_miso = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'h0};
        end
        // Input sampled on the falling serial clock
        if (sck_fall) begin
            next_shift_in = {shift_in[14:0], mosi_s};
            if (cnt != 5'h1f) begin
                next_cnt = cnt + 5'h01;
            end
            // Address byte complete: register data go out next
            if (cnt + 5'h01 == `ADIU_LOAD_EDGE) begin
                next_shift_out = rd_data;
            end
        end
        // Write only with exactly sixteen edges and good parity
        if (ss_rise && cnt == `ADIU_FRAME_EDGES && !shift_in[15] && parity_ok) begin
            next_wreq.wr = 1'h1;
            next_wreq.addr = shift_in[14:10];
            next_wreq.data = shift_in[7:0];
        end
    end

    // Registers of the serial port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Idle pin levels: deselected, clock low, so no false edge
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            ss_n_d <= 1'h1;
            sck_d <= 1'h0;
            cnt <= 5'h00;
            shift_in <= 16'h0000;
            shift_out <= 8'h00;
            miso <= 1'h0;
            miso_oe <= 1'h0;
            wreq <= '0;
        end else if (ce) begin
            sync1 <= {ss_n_pin, sck_pin, mosi_pin};
            sync2 <= sync1;
            ss_n_d <= ss_n_s;
            sck_d <= sck_s;
            cnt <= next_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            miso <= next_miso;
            miso_oe <= ~ss_n_s;
            wreq <= next_wreq;
        end
    end
endmodule

// ### logic/adiu_top.sv
`timescale 1ns/100ps
`include "adiu_regs.svh"
module adiu_top (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic SS_N,
    input wire logic SPI_CLK,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    input wire logic UNDERVOLTAGE_EVENT,
    input wire logic OVERVOLTAGE_EVENT,
    input wire logic OVERTEMPERATURE_EVENT,
    input wire logic BUS_LINE,
    input wire logic OVERCURRENT_BRIDGE,
    input wire logic OVERCURRENT_SWITCHED_5V_OUTPUT,
    input wire logic OVERCURRENT_CLEAR,
    output logic HIGH_SIDE_OFF,
    output logic IRQ_O,
    output logic IRQ_OE
);
    import adiu_pkg::*;

    // Two-stage synchronisers for the asynchronous detector pins
    logic [5:0] sync1;
    logic [5:0] sync2;
    // Previous synchronised bus level for edge detection
    logic bus_prev;
    // Sticky flags and enables
    adiu_evt_type flag;
    adiu_evt_type enable;
    adiu_evt_type next_flag;
    adiu_evt_type next_enable;
    // Synchronised conditions
    adiu_evt_type cond;
    logic bus_s;
    logic bus_fell;
    logic next_hs_off;
    logic next_irq;
    // Serial port connections
    adiu_wreq_type wreq;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_flags;
    logic wr_enable;

    // Place the five event bits into a register byte
    function automatic logic [7:0] pack_byte(input adiu_evt_type e);
        pack_byte = {2'h0, e, 1'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Serial register port
    adiu_spi_slave u_spi (
        .clk(MCLK),
        .rst(RESET),
        .ce(CE),
        .ss_n_pin(SS_N),
        .sck_pin(SPI_CLK),
        .mosi_pin(SPI_MOSI),
        .status_byte(pack_byte(flag)),
        .rd_data(rd_data),
        .rd_addr(rd_addr),
        .miso(SPI_MISO),
        .miso_oe(SPI_MISO_OE),
        .wreq(wreq)
    );

    // Read decode; unmapped addresses read zero
    // Flags and enables share one bit layout
    always_comb begin
        case (rd_addr)
            `ADIU_ADDR_ENABLE: rd_data = pack_byte(enable);
            `ADIU_ADDR_FLAGS: rd_data = pack_byte(flag);
            default: rd_data = 8'h00;
        endcase
    end

    // Write strobes for the two registers
    assign wr_flags = wreq.wr && wreq.addr == `ADIU_ADDR_FLAGS;
    assign wr_enable = wreq.wr && wreq.addr == `ADIU_ADDR_ENABLE;

    ////////////////////////////////////////////////////////////////////
    // Condition decode
    always_comb begin
        // R1: five separate sources
        cond.undervoltage = sync2[0];
        cond.overvoltage = sync2[1];
        cond.overtemperature = sync2[2];
        // R10: either overcurrent detector counts
        cond.overcurrent = sync2[4] | sync2[5];
        // Bus event is a falling edge, not a level condition
        cond.bus_fall = 1'h0;
        bus_s = sync2[3];
        bus_fell = bus_prev & ~bus_s;
    end

    // Next flags and enables; a set always wins over a clear
    always_comb begin
        next_flag = flag;
        next_enable = enable;
        // R12: bus edge sets, written one clears
        next_flag.bus_fall = bus_fell | (flag.bus_fall & ~(wr_flags & wreq.data[`ADIU_BIT_BUS]));
        // R8 R13: clear has no effect while hot
        next_flag.overtemperature = cond.overtemperature
            | (flag.overtemperature & ~(wr_flags & wreq.data[`ADIU_BIT_OT]));
        // R4 R14: clear only after undervoltage ended
        next_flag.undervoltage = cond.undervoltage
            | (flag.undervoltage & ~(wr_flags & wreq.data[`ADIU_BIT_UV]));
        // R6 R16: clear ignored during overvoltage
        next_flag.overvoltage = cond.overvoltage
            | (flag.overvoltage & ~(wr_flags & wreq.data[`ADIU_BIT_OV]));
        // R18: cleared from the system status side only
        next_flag.overcurrent = cond.overcurrent | (flag.overcurrent & ~OVERCURRENT_CLEAR);
        // R2 R17: enable register write
        if (wr_enable) begin
            next_enable = wreq.data[`ADIU_BIT_BUS:`ADIU_BIT_OC];
        end
        // R5 R7: supply faults switch high sides off
        next_hs_off = cond.undervoltage | cond.overvoltage;
        // R9 R19: any enabled flag asserts the line
        next_irq = |(flag & enable);
    end

    // State registers
    always_ff @(posedge MCLK or posedge RESET) begin
        // R3 R11: flags, outputs clear and sources disabled after reset
        if (RESET) begin
            // Synchronisers come up at idle pin levels
            sync1 <= 6'h08;
            sync2 <= 6'h08;
            bus_prev <= 1'h1;
            flag <= '0;
            enable <= '0;
            HIGH_SIDE_OFF <= 1'h0;
            IRQ_OE <= 1'h0;
        end else if (CE) begin
            // Clock enable low freezes all state
            sync1 <= {OVERCURRENT_SWITCHED_5V_OUTPUT, OVERCURRENT_BRIDGE, BUS_LINE,
                      OVERTEMPERATURE_EVENT, OVERVOLTAGE_EVENT, UNDERVOLTAGE_EVENT};
            sync2 <= sync1;
            bus_prev <= bus_s;
            flag <= next_flag;
            enable <= next_enable;
            HIGH_SIDE_OFF <= next_hs_off;
            IRQ_OE <= next_irq;
        end
    end

    // R15: open-drain line only ever pulls low
    assign IRQ_O = 1'h0;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    // Checks sample the system clock and sleep in reset

    // R12: bus edge reaches flag
    bus_edge_sets_a: assert property (CE && bus_fell |=> flag.bus_fall) // R12
        else $error("bus edge did not set flag");
    // R12: zero write leaves bus flag
    bus_zero_write_a: assert property (CE && wr_flags && !wreq.data[5] && flag.bus_fall |=> flag.bus_fall) // R12
        else $error("zero write cleared bus flag");
    // R12: one write clears quiet bus flag
    bus_one_clear_a: assert property (CE && wr_flags && wreq.data[5] && !bus_fell |=> !flag.bus_fall) // R12
        else $error("one write did not clear bus flag");
    // R13: hot condition keeps flag
    hot_clear_held_a: assert property (CE && cond.overtemperature |=> flag.overtemperature) // R13
        else $error("overtemperature flag lost");
    // R13: clear accepted once cooled
    ot_clear_done_a: assert property (CE && wr_flags && wreq.data[4] && !cond.overtemperature // R13
        |=> !flag.overtemperature) else $error("overtemperature flag not cleared");
    // R4: low supply sets flag
    low_sets_a: assert property (CE && cond.undervoltage |=> flag.undervoltage) // R4
        else $error("undervoltage flag not set");
    // R14: clear refused during undervoltage
    low_clear_held_a: assert property (CE && cond.undervoltage && wr_flags |=> flag.undervoltage) // R14
        else $error("undervoltage flag cleared too early");
    // R14: clear accepted once supply recovered
    uv_clear_done_a: assert property (CE && wr_flags && wreq.data[3] && !cond.undervoltage // R14
        |=> !flag.undervoltage) else $error("undervoltage flag not cleared");
    // R16: overvoltage keeps flag
    high_clear_held_a: assert property (CE && cond.overvoltage |=> flag.overvoltage) // R16
        else $error("overvoltage flag lost");
    // R16: clear accepted once supply normal
    ov_clear_done_a: assert property (CE && wr_flags && wreq.data[2] && !cond.overvoltage // R16
        |=> !flag.overvoltage) else $error("overvoltage flag not cleared");
    // R10: either detector sets flag
    overcurrent_set_a: assert property (CE && (sync2[4] || sync2[5]) |=> flag.overcurrent) // R10
        else $error("overcurrent flag not set");
    // R18: register write cannot clear overcurrent
    oc_write_kept_a: assert property (CE && wr_flags && !OVERCURRENT_CLEAR && flag.overcurrent // R18
        |=> flag.overcurrent) else $error("overcurrent flag cleared by write");
    // R18: status side clear takes effect
    oc_clear_a: assert property (CE && OVERCURRENT_CLEAR && !cond.overcurrent |=> !flag.overcurrent) // R18
        else $error("overcurrent flag not cleared");
    // R17: enable write lands
    enable_write_a: assert property (CE && wr_enable |=> enable == $past(wreq.data[5:1])) // R17
        else $error("enable register write lost");
    // R3: enables move only on write
    enable_held_a: assert property (CE && !wr_enable |=> enable == $past(enable)) // R3
        else $error("enable changed without write");
    // R5: supply fault forces high sides off
    high_side_off_a: assert property (CE && (cond.undervoltage || cond.overvoltage) |=> HIGH_SIDE_OFF) // R5
        else $error("high sides not forced off");
    // R7: high sides freed once supply good
    high_side_on_a: assert property (CE && !cond.undervoltage && !cond.overvoltage |=> !HIGH_SIDE_OFF) // R7
        else $error("high sides held off without fault");
    // R19: line released without enabled flag
    irq_follows_a: assert property (CE && !(|(flag & enable)) |=> !IRQ_OE) // R19
        else $error("interrupt line held without enabled flag");
    // R19: line pulled with enabled flag
    irq_asserts_a: assert property (CE && |(flag & enable) |=> IRQ_OE) // R19
        else $error("interrupt line not asserted");

    // Main scenarios reached
    bus_irq_c: cover property (enable.bus_fall && bus_fell ##2 IRQ_OE);
    clear_flag_c: cover property (wr_flags && flag.undervoltage && !cond.undervoltage ##1 !flag.undervoltage);
    blocked_clear_c: cover property (wr_flags && cond.overtemperature);
    enable_write_c: cover property (wr_enable ##1 |enable);
    supply_off_c: cover property ($rose(HIGH_SIDE_OFF));
endmodule

// ### tb/adiu_bench.sv
`timescale 1ns/100ps
`include "adiu_regs.svh"
module adiu_bench;
    logic mclk, reset, uv, ov, ot, bus, ocb, oc5, occlr;
    logic miso, miso_oe, ss_n, sck, mosi, hso, irq_o, irq_oe, irq_line;
    logic [15:0] rx;
    int miscompares = 0;
    int n_tests = 0;
    adiu_top dut_u (.MCLK(mclk), .RESET(reset), .CE(1'b1), .SS_N(ss_n), .SPI_CLK(sck), .SPI_MOSI(mosi),
        .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .UNDERVOLTAGE_EVENT(uv), .OVERVOLTAGE_EVENT(ov),
        .OVERTEMPERATURE_EVENT(ot), .BUS_LINE(bus), .OVERCURRENT_BRIDGE(ocb),
        .OVERCURRENT_SWITCHED_5V_OUTPUT(oc5), .OVERCURRENT_CLEAR(occlr), .HIGH_SIDE_OFF(hso),
        .IRQ_O(irq_o), .IRQ_OE(irq_oe));
    adiu_mcu_model mcu_u (.clk(mclk), .miso(miso), .miso_oe(miso_oe), .irq_o(irq_o), .irq_oe(irq_oe),
        .ss_n(ss_n), .sck(sck), .mosi(mosi), .irq_line(irq_line));
    ////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Register write and read frames
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        mcu_u.xfer(1'b0, a, d, 16, 1'b0, 4, rx);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        mcu_u.xfer(1'b1, a, 8'h00, 16, 1'b0, 4, rx);
        check("register read", rx[7:0], exp);
    endtask
    // Let synchronisers and flags settle
    task automatic settle();
        repeat (6) @(negedge mclk);
    endtask
    // Bounded wait for the interrupt line level
    task automatic wait_irq(input logic exp);
        int k;
        for (k = 0; k < 20 && irq_line !== exp; k++) @(negedge mclk);
        check("interrupt line", {7'h00, irq_line}, {7'h00, exp});
        if (irq_line !== exp) end_sim();
    endtask
    // Drive one event source by its register bit
    task automatic set_src(input int i, input logic v);
        case (i)
            1: oc5 = v;
            2: ov = v;
            3: uv = v;
            4: ot = v;
            default: bus = ~v;
        endcase
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        {uv, ov, ot, ocb, oc5, occlr} = 6'h00;
        bus = 1'b1;
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        rd(`ADIU_ADDR_ENABLE, 8'h00);
        rd(`ADIU_ADDR_FLAGS, 8'h00);
        wait_irq(1'b1);
        $display("test reset values done");
        uv = 1'b1;
        ov = 1'b1;
        ot = 1'b1;
        ocb = 1'b1;
        bus = 1'b0;
        settle();
        check("high side off", {7'h00, hso}, 8'h01);
        rd(`ADIU_ADDR_ENABLE, 8'h00);
        check("status byte", rx[15:8], 8'h3e);
        rd(`ADIU_ADDR_FLAGS, 8'h3e);
        wait_irq(1'b1);
        wr(`ADIU_ADDR_FLAGS, 8'h00);
        rd(`ADIU_ADDR_FLAGS, 8'h3e);
        wr(`ADIU_ADDR_FLAGS, 8'hff);
        rd(`ADIU_ADDR_FLAGS, 8'h1e);
        $display("test disabled events done");
        {uv, ov, ot, ocb} = 4'h0;
        bus = 1'b1;
        settle();
        check("high side off", {7'h00, hso}, 8'h00);
        wr(`ADIU_ADDR_FLAGS, 8'hff);
        rd(`ADIU_ADDR_FLAGS, 8'h02);
        occlr = 1'b1;
        @(negedge mclk);
        occlr = 1'b0;
        settle();
        rd(`ADIU_ADDR_FLAGS, 8'h00);
        $display("test flag clearing done");
        for (int i = 1; i <= 5; i++) begin
            wr(`ADIU_ADDR_ENABLE, 8'h01 << i);
            rd(`ADIU_ADDR_ENABLE, 8'h01 << i);
            set_src(i, 1'b1);
            wait_irq(1'b0);
            rd(`ADIU_ADDR_FLAGS, 8'h01 << i);
            set_src(i, 1'b0);
            settle();
            if (i == 1) begin
                occlr = 1'b1;
                @(negedge mclk);
                occlr = 1'b0;
            end else begin
                wr(`ADIU_ADDR_FLAGS, 8'h01 << i);
            end
            wait_irq(1'b1);
        end
        $display("test enabled sources done");
        mcu_u.xfer(1'b0, `ADIU_ADDR_ENABLE, 8'h3e, 16, 1'b1, 4, rx);
        mcu_u.xfer(1'b0, `ADIU_ADDR_ENABLE, 8'h3e, 15, 1'b0, 4, rx);
        rd(`ADIU_ADDR_ENABLE, 8'h20);
        mcu_u.xfer(1'b0, `ADIU_ADDR_ENABLE, 8'hff, 16, 1'b0, 9, rx);
        rd(`ADIU_ADDR_ENABLE, 8'h3e);
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00);
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
        rd(`ADIU_ADDR_ENABLE, 8'h00);
        $display("test refused frames and reset done");
        end_sim();
    end
endmodule

// ### tb/adiu_mcu_model.sv
`timescale 1ns/100ps
module adiu_mcu_model (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic irq_o,
    input wire logic irq_oe,
    output logic ss_n,
    output logic sck,
    output logic mosi,
    output logic irq_line
);
    assign irq_line = irq_oe ? irq_o : 1'b1;
    // Idle: deselected, clock parked low
    initial begin
        ss_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    task automatic xfer(input logic rw, input logic [4:0] addr, input logic [7:0] data, input int nbits,
        input logic bad_par, input int ph, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {rw, addr, (^{rw, addr}) ^ bad_par, 1'b0, data};
        rx = 16'h0000;
        @(negedge clk);
        ss_n = 1'b0;
        repeat (ph) @(negedge clk);
        // Data out with the rise, slave samples on the fall
        for (int i = 15; i > 15 - nbits; i--) begin
            sck = 1'b1;
            mosi = tx[i];
            repeat (ph) @(negedge clk);
            rx[i] = miso_oe ? miso : 1'bz;
            sck = 1'b0;
            repeat (ph) @(negedge clk);
        end
        ss_n = 1'b1;
        // Released data line does not keep its last value
        mosi = ~mosi;
        repeat (8) @(negedge clk);
    endtask
endmodule
